// [inc/offset_correction_pkg.sv]
package offset_correction_pkg;

   // register byte offsets on the apb bus
   localparam logic [11:0] ADDR_LOOP_CTRL     = 12'h000;
   localparam logic [11:0] ADDR_REDUCED_RATE  = 12'h004;
   localparam logic [11:0] ADDR_CORR_CTRL     = 12'h008;
   localparam logic [11:0] ADDR_PEDESTAL      = 12'h00C;
   localparam logic [11:0] ADDR_ESTIMATE      = 12'h010;

   // field positions in offset_loop_control
   localparam int LOOP_HOLD_BIT      = 7;
   localparam int SPAN_LSB           = 2;
   localparam int SPAN_MSB           = 5;
   // field positions in reduced_rate_control
   localparam int RATE_LSB           = 4;
   localparam int RATE_MSB           = 5;
   // field positions in the correction control register
   localparam int FORMAT_LSB         = 6;
   localparam int FORMAT_MSB         = 7;
   localparam int CORR_ENABLE_BIT    = 5;
   localparam int DIGITAL_PATH_BIT   = 3;
   localparam int DDR_MODE_BIT       = 0;
   // field positions in the pedestal register
   localparam int PEDESTAL_LSB       = 2;
   localparam int PEDESTAL_MSB       = 7;

   // writable masks (reserved bits are dropped and read as zero)
   localparam logic [7:0] LOOP_CTRL_MASK  = 8'hBC;
   localparam logic [7:0] RATE_MASK       = 8'h30;
   localparam logic [7:0] CORR_CTRL_MASK  = 8'hE9;
   localparam logic [7:0] PEDESTAL_MASK   = 8'hFC;

   // values after reset
   localparam logic [7:0] LOOP_CTRL_RESET = 8'h00;
   localparam logic [7:0] RATE_RESET_HI   = 8'h00;
   localparam logic [7:0] RATE_RESET_LO   = 8'h30;
   localparam logic [7:0] CORR_CTRL_RESET = 8'h00;
   localparam logic [7:0] PEDESTAL_RESET  = 8'h00;

   // codes
   localparam logic [1:0] RATE_ENABLE_CODE = 2'b11;
   localparam logic [1:0] FORMAT_TWOS      = 2'b10;
   localparam logic [1:0] FORMAT_OFFSET    = 2'b11;
   localparam logic [3:0] SPAN_MAX_CODE    = 4'b1011;

   // loop span: code 0 is 2**20 clock cycles, each code up to 11 doubles it
   localparam int SPAN_BASE_LOG2   = 20;
   localparam int SPAN_CODE_MAX    = 11;

   // pipeline: edges from sampling to output word
   localparam int PIPE_LATENCY     = 10;
   localparam int PIPE_FIXED       = 3;

   // loop settings carried together
   typedef struct packed {
      logic       enable;
      logic       hold;
      logic [3:0] span;
   } loop_cfg_t;

endpackage

// [src/sample_delay_line.sv]
`timescale 1ns/100ps
module sample_delay_line #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 7
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   // sample stream
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] stage [DEPTH];

   // one stage per edge, frozen while the clock enable is low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < DEPTH; i++) begin
            stage[i] <= '0;
         end
      end else if (ce) begin
         stage[0] <= din;
         for (int i = 1; i < DEPTH; i++) begin
            stage[i] <= stage[i-1];
         end
      end
   end

   assign dout = stage[DEPTH-1];

endmodule

// [src/offset_correction_control.sv]
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module offset_correction_control #(
   parameter int   DATA_WIDTH       = 14,
   parameter logic LOW_RATE_VARIANT = 1'b0,
   parameter int   SPAN_BASE_LOG2   = offset_correction_pkg::SPAN_BASE_LOG2
) (
   // clock, reset, enable
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  ce,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // converter core samples (offset binary, same clock) and format pin
   input  wire logic [DATA_WIDTH-1:0] adc_sample,
   input  wire logic                  format_pin,
   // output word to the receiver
   output logic      [DATA_WIDTH-1:0] out_data,
   output logic                       out_twos,
   output logic                       ddr_mode,
   // status
   output logic                       reduced_rate_active,
   output logic                       correction_active
);

   localparam int SW    = DATA_WIDTH + 2;
   localparam int ACC_W = SW + SPAN_BASE_LOG2 + offset_correction_pkg::SPAN_CODE_MAX + 1;
   localparam int DEPTH = offset_correction_pkg::PIPE_LATENCY - offset_correction_pkg::PIPE_FIXED;
   localparam logic signed [SW-1:0] MID    = SW'(1 << (DATA_WIDTH - 1));
   localparam logic signed [SW-1:0] OUT_LO = -MID;
   localparam logic signed [SW-1:0] OUT_HI = MID - SW'(1);
   localparam logic signed [SW-1:0] EST_HI = SW'((1 << DATA_WIDTH) - 1);
   localparam logic signed [SW-1:0] EST_LO = -EST_HI;

   // clamp a wide signed value into the working range
   function automatic logic signed [SW-1:0] clamp(input logic signed [ACC_W-1:0] v,
                                                  input logic signed [SW-1:0]    lo,
                                                  input logic signed [SW-1:0]    hi);
      logic signed [ACC_W-1:0] lo_w;
      logic signed [ACC_W-1:0] hi_w;
      lo_w = ACC_W'(lo);
      hi_w = ACC_W'(hi);
      if (v < lo_w) begin
         return lo;
      end else if (v > hi_w) begin
         return hi;
      end else begin
         return v[SW-1:0];
      end
   endfunction

   // register storage
   logic [7:0]                  loop_ctrl;
   logic [7:0]                  rate_ctrl;
   logic [7:0]                  corr_ctrl;
   logic [7:0]                  pedestal_reg;

   // datapath state
   logic [DATA_WIDTH-1:0]       cap_q;
   logic [DATA_WIDTH-1:0]       dly;
   logic signed [SW-1:0]        corr_q;
   logic                        corr_valid_q;
   logic signed [ACC_W-1:0]     acc;
   logic                        fmt_sync1;
   logic                        fmt_sync2;

   // combinational
   offset_correction_pkg::loop_cfg_t cfg;
   logic                        digital_on;
   logic                        loop_on;
   logic [4:0]                  shift;
   logic signed [SW-1:0]        est;
   logic signed [SW-1:0]        s_in;
   logic signed [SW-1:0]        target;
   logic signed [SW-1:0]        next_corr;
   logic signed [ACC_W-1:0]     next_acc;
   logic                        next_twos;
   logic                        bus_access;
   logic                        bus_write;
   logic                        lane0;
   logic [31:0]                 next_prdata;
   logic                        next_pslverr;

   // loop settings; low-latency mode removes the offset loop, while output coding and ddr mode still apply
   assign digital_on = corr_ctrl[offset_correction_pkg::DIGITAL_PATH_BIT];
   assign cfg.enable = corr_ctrl[offset_correction_pkg::CORR_ENABLE_BIT] & digital_on;
   assign cfg.hold   = loop_ctrl[offset_correction_pkg::LOOP_HOLD_BIT];
   assign cfg.span   = loop_ctrl[offset_correction_pkg::SPAN_MSB:offset_correction_pkg::SPAN_LSB];
   assign loop_on    = cfg.enable;

   // time constant of 2**(base+code) cycles; codes above 11 act as 11
   always_comb begin
      if (cfg.span > offset_correction_pkg::SPAN_MAX_CODE) begin
         shift = 5'(SPAN_BASE_LOG2 + offset_correction_pkg::SPAN_CODE_MAX);
      end else begin
         shift = 5'(SPAN_BASE_LOG2) + {1'b0, cfg.span};
      end
   end

   // estimate is the accumulator scaled by the span
   assign est = clamp(acc >>> shift, EST_LO, EST_HI);

   // sample centred on mid-code, and the converged value mid-code plus pedestal
   assign s_in   = $signed({2'b00, dly}) - MID;
   assign target = SW'($signed(pedestal_reg[offset_correction_pkg::PEDESTAL_MSB:
                                            offset_correction_pkg::PEDESTAL_LSB]));

   // the estimate is subtracted whether the loop is tracking or held
   always_comb begin
      if (loop_on) begin
         next_corr = clamp(ACC_W'(s_in) - ACC_W'(est), OUT_LO, OUT_HI);
      end else begin
         next_corr = s_in;
      end
   end

   // integrate the error against the target; held value kept across a hold
   always_comb begin
      if (!loop_on) begin
         next_acc = '0;
      end else if (cfg.hold) begin
         next_acc = acc;
      end else if (corr_valid_q) begin
         next_acc = acc + ACC_W'(corr_q) - ACC_W'(target);
      end else begin
         next_acc = acc;
      end
   end

   // sampling edge: capture the converter word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_q <= '0;
      end else if (ce) begin
         cap_q <= adc_sample;
      end
   end

   // middle of the pipeline
   sample_delay_line #(
      .WIDTH (DATA_WIDTH),
      .DEPTH (DEPTH)
   ) u_delay (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .din     (cap_q),
      .dout    (dly)
   );

   // correction stage; valid is set on the first enabled edge after reset, before the pipeline has filled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         corr_q       <= '0;
         corr_valid_q <= 1'b0;
      end else if (ce) begin
         corr_q       <= next_corr;
         corr_valid_q <= 1'b1;
      end
   end

   // offset loop accumulator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc <= '0;
      end else if (ce) begin
         acc <= next_acc;
      end
   end

   // format pin comes from outside, two flops before use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fmt_sync1 <= 1'b0;
         fmt_sync2 <= 1'b0;
      end else if (ce) begin
         fmt_sync1 <= format_pin;
         fmt_sync2 <= fmt_sync1;
      end
   end

   // coding select: register code wins, otherwise the pin decides
   always_comb begin
      unique case (corr_ctrl[offset_correction_pkg::FORMAT_MSB:offset_correction_pkg::FORMAT_LSB])
         offset_correction_pkg::FORMAT_TWOS:   next_twos = 1'b1;
         offset_correction_pkg::FORMAT_OFFSET: next_twos = 1'b0;
         default:                              next_twos = fmt_sync2;
      endcase
   end

   // output stage: tenth edge after sampling
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_data <= '0;
         out_twos <= 1'b0;
      end else if (ce) begin
         out_twos <= next_twos;
         if (next_twos) begin
            out_data <= corr_q[DATA_WIDTH-1:0];
         end else begin
            out_data <= DATA_WIDTH'(corr_q + MID);
         end
      end
   end

   // status outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ddr_mode            <= 1'b0;
         correction_active   <= 1'b0;
         reduced_rate_active <= LOW_RATE_VARIANT;
      end else if (ce) begin
         ddr_mode            <= corr_ctrl[offset_correction_pkg::DDR_MODE_BIT];
         correction_active   <= loop_on;
         if (LOW_RATE_VARIANT) begin
            reduced_rate_active <= 1'b1;
         end else begin
            reduced_rate_active <= (rate_ctrl[offset_correction_pkg::RATE_MSB:offset_correction_pkg::RATE_LSB]
                                    == offset_correction_pkg::RATE_ENABLE_CODE);
         end
      end
   end

   // apb: access phase answered one cycle later, write lands on the ready edge
   assign bus_access = psel & penable & ~pready;
   assign bus_write  = psel & penable & pready & pwrite;
   assign lane0      = pstrb[0];

   // read mux and address decode
   always_comb begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      unique case (paddr)
         offset_correction_pkg::ADDR_LOOP_CTRL:    next_prdata = {24'h00_0000, loop_ctrl};
         offset_correction_pkg::ADDR_REDUCED_RATE: next_prdata = {24'h00_0000, rate_ctrl};
         offset_correction_pkg::ADDR_CORR_CTRL:    next_prdata = {24'h00_0000, corr_ctrl};
         offset_correction_pkg::ADDR_PEDESTAL:     next_prdata = {24'h00_0000, pedestal_reg};
         offset_correction_pkg::ADDR_ESTIMATE: begin
            next_prdata  = {{(32 - SW){est[SW-1]}}, est};
            next_pslverr = pwrite;
         end
         default: begin
            next_pslverr = 1'b1;
         end
      endcase
   end

   // bus handshake registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready  <= bus_access;
         if (bus_access) begin
            prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_pslverr;
         end else begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
         end
      end
   end

   // loop control register; reserved bits dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loop_ctrl <= offset_correction_pkg::LOOP_CTRL_RESET;
      end else if (ce && bus_write && lane0 && paddr == offset_correction_pkg::ADDR_LOOP_CTRL) begin
         loop_ctrl <= pwdata[7:0] & offset_correction_pkg::LOOP_CTRL_MASK;
      end
   end

   // reduced-rate register; fixed on the lower-rate variant
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rate_ctrl <= LOW_RATE_VARIANT ? offset_correction_pkg::RATE_RESET_LO
                                       : offset_correction_pkg::RATE_RESET_HI;
      end else if (ce && bus_write && lane0 && !LOW_RATE_VARIANT
                   && paddr == offset_correction_pkg::ADDR_REDUCED_RATE) begin
         rate_ctrl <= pwdata[7:0] & offset_correction_pkg::RATE_MASK;
      end
   end

   // correction control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         corr_ctrl <= offset_correction_pkg::CORR_CTRL_RESET;
      end else if (ce && bus_write && lane0 && paddr == offset_correction_pkg::ADDR_CORR_CTRL) begin
         corr_ctrl <= pwdata[7:0] & offset_correction_pkg::CORR_CTRL_MASK;
      end
   end

   // pedestal register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pedestal_reg <= offset_correction_pkg::PEDESTAL_RESET;
      end else if (ce && bus_write && lane0 && paddr == offset_correction_pkg::ADDR_PEDESTAL) begin
         pedestal_reg <= pwdata[7:0] & offset_correction_pkg::PEDESTAL_MASK;
      end
   end

endmodule

// [dv/offset_correction_properties.sv]
`timescale 1ns/100ps
module offset_correction_properties #(
   parameter int   DATA_WIDTH       = 14,
   parameter logic LOW_RATE_VARIANT = 1'b0
) (
   // clock and reset
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic                  ce,
   // apb
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [11:0]           paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [3:0]            pstrb,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   // samples and status
   input wire logic [DATA_WIDTH-1:0] adc_sample,
   input wire logic                  format_pin,
   input wire logic [DATA_WIDTH-1:0] out_data,
   input wire logic                  out_twos,
   input wire logic                  ddr_mode,
   input wire logic                  reduced_rate_active,
   input wire logic                  correction_active
);
   logic [7:0]            loop_s;
   logic [7:0]            corr_s;
   logic [1:0]            rate_s;
   logic [3:0]            run;
   logic [3:0]            hrun;
   logic                  twos_q;
   logic [DATA_WIDTH-1:0] samp_q;
   logic                  wr;

   // a write that completes without error
   assign wr = psel && penable && pready && pwrite && pstrb[0] && ce && !pslverr;

   // shadow of the control bytes as software wrote them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loop_s <= 8'h00;
         corr_s <= 8'h00;
         rate_s <= 2'b00;
      end else if (wr) begin
         if (paddr == offset_correction_pkg::ADDR_LOOP_CTRL) loop_s <= pwdata[7:0];
         if (paddr == offset_correction_pkg::ADDR_CORR_CTRL) corr_s <= pwdata[7:0];
         if (paddr == offset_correction_pkg::ADDR_REDUCED_RATE) rate_s <= pwdata[5:4];
      end
   end

   // runs of steady bypass traffic and of held correction on a constant input
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run    <= 4'h0;
         hrun   <= 4'h0;
         twos_q <= 1'b0;
         samp_q <= '0;
      end else begin
         run    <= (!ce || wr || correction_active || out_twos != twos_q) ? 4'h0 : run + 4'(run != 4'hF);
         hrun   <= (!ce || wr || !correction_active || !loop_s[7] || adc_sample != samp_q) ? 4'h0
                   : hrun + 4'(hrun != 4'hF);
         twos_q <= out_twos;
         samp_q <= adc_sample;
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   pipe_latency_a: assert property (run >= 4'd12 |-> out_data == ($past(adc_sample, 10)
      ^ {out_twos, {(DATA_WIDTH-1){1'b0}}})) else $error("bypass word not the sample of ten edges ago");
   hold_freeze_a: assert property (hrun >= 4'd12 |-> $stable(out_data))
      else $error("held correction changed the output");
   corr_gate_a: assert property ($stable(corr_s)[*3] |-> correction_active == (corr_s[5] && corr_s[3]))
      else $error("correction activity disagrees with enable and path");
   ddr_follow_a: assert property ($stable(corr_s)[*3] |-> ddr_mode == corr_s[0])
      else $error("ddr mode disagrees with control");
   format_code_a: assert property ($stable(corr_s)[*3] && corr_s[7] |-> out_twos == !corr_s[6])
      else $error("output coding disagrees with format code");
   reduced_rate_a: assert property ($stable(rate_s)[*3]
      |-> reduced_rate_active == (LOW_RATE_VARIANT || rate_s == 2'b11)) else $error("reduced rate state wrong");
   apb_answer_a: assert property (psel && penable && !pready && ce |=> pready)
      else $error("no answer one cycle after access");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data outside answer cycle");
   est_readonly_a: assert property (psel && penable && pready && pwrite
      && paddr == offset_correction_pkg::ADDR_ESTIMATE |-> pslverr) else $error("estimate write not refused");

   cover property (hrun == 4'd12);
   cover property (run == 4'd12);
   cover property (pready && pslverr);
   cover property (reduced_rate_active && !LOW_RATE_VARIANT);
endmodule

bind offset_correction_control offset_correction_properties #(
   .DATA_WIDTH      (DATA_WIDTH),
   .LOW_RATE_VARIANT(LOW_RATE_VARIANT)
) offset_correction_properties_inst (
   .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .adc_sample(adc_sample), .format_pin(format_pin), .out_data(out_data), .out_twos(out_twos),
   .ddr_mode(ddr_mode), .reduced_rate_active(reduced_rate_active), .correction_active(correction_active)
);

// [dv/sample_receiver.sv]
`timescale 1ns/100ps
module sample_receiver #(
   parameter int DATA_WIDTH = 14
) (
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // word from the converter
   input  wire logic [DATA_WIDTH-1:0] out_data,
   input  wire logic                  out_twos,
   // captured word, always offset binary
   output logic      [DATA_WIDTH-1:0] rx_word
);
   // capture each word on the rising edge and undo two's complement coding
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_word <= '0;
      end else begin
         rx_word <= out_data ^ {out_twos, {(DATA_WIDTH-1){1'b0}}};
      end
   end
endmodule

// [dv/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
   localparam int DW = 14;
   logic          pclk       = 1'b0;
   logic          presetn    = 1'b0;
   logic          ce         = 1'b1;
   logic          psel       = 1'b0;
   logic          penable    = 1'b0;
   logic          pwrite     = 1'b0;
   logic [11:0]   paddr      = 12'h000;
   logic [31:0]   pwdata     = 32'h0000_0000;
   logic [3:0]    pstrb      = 4'hF;
   logic [DW-1:0] adc_sample = 14'h0000;
   logic          format_pin = 1'b0;
   logic          ramp_on    = 1'b0;
   logic [31:0]   prdata, rdata;
   logic          pready, pslverr, rerr, out_twos, ddr_mode, reduced_rate_active, correction_active;
   logic [DW-1:0] out_data, rx_word;
   int            mismatches = 0;
   int            checks     = 0;

   offset_correction_control #(.DATA_WIDTH(DW), .LOW_RATE_VARIANT(1'b0), .SPAN_BASE_LOG2(2))
   offset_correction_control_inst (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .adc_sample(adc_sample), .format_pin(format_pin), .out_data(out_data), .out_twos(out_twos),
      .ddr_mode(ddr_mode), .reduced_rate_active(reduced_rate_active), .correction_active(correction_active));

   sample_receiver #(.DATA_WIDTH(DW)) sample_receiver_inst (
      .pclk(pclk), .presetn(presetn), .out_data(out_data), .out_twos(out_twos), .rx_word(rx_word));

   // clock and a ramp of samples, one step per edge
   always #5 pclk = ~pclk;
   always @(posedge pclk) if (ramp_on) adc_sample <= adc_sample + 14'h0001;

   task automatic give_verdict();
      if (mismatches == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one apb transfer, entered just after a rising edge
   task automatic apb(input int wr, input logic [11:0] addr, input logic [31:0] data);
      int   n;
      logic seen;
      n = 0;
      psel    <= 1'b1;
      pwrite  <= 1'(wr);
      paddr   <= addr;
      pwdata  <= data;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      seen  = pready;
      rdata = prdata;
      rerr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      // a transfer that never saw its answer ends the run
      if (seen !== 1'b1) begin
         chk("pready", 32'h1, 32'(seen));
         give_verdict();
      end
   endtask

   // wait a bounded time for the captured word, then compare
   task automatic wait_rx(input string name, input logic [DW-1:0] exp, input int n);
      for (int i = 0; i < n && rx_word !== exp; i++) @(posedge pclk);
      chk(name, 32'(exp), 32'(rx_word));
      // a wait that used up its bound goes straight to the report
      if (rx_word !== exp) begin
         give_verdict();
      end
   endtask

   // reset values, writable fields and refused accesses
   task automatic t_regs();
      apb(0, offset_correction_pkg::ADDR_LOOP_CTRL, 0); chk("loop_rst", 32'(offset_correction_pkg::LOOP_CTRL_RESET), rdata);
      apb(1, offset_correction_pkg::ADDR_LOOP_CTRL, 32'h0000_00BC);
      apb(0, offset_correction_pkg::ADDR_LOOP_CTRL, 0); chk("loop_rw", 32'h0000_00BC, rdata);
      apb(1, offset_correction_pkg::ADDR_LOOP_CTRL, 0);
      apb(0, offset_correction_pkg::ADDR_REDUCED_RATE, 0); chk("rate_rst", 32'h0, rdata);
      for (int c = 0; c < 4; c++) begin
         apb(1, offset_correction_pkg::ADDR_REDUCED_RATE, 32'(c << 4));
         repeat (3) @(posedge pclk);
         chk("rate_on", 32'(c == 3), 32'(reduced_rate_active));
      end
      apb(1, offset_correction_pkg::ADDR_REDUCED_RATE, 0);
      apb(1, offset_correction_pkg::ADDR_ESTIMATE, 32'h0000_0011); chk("est_wr", 32'h1, 32'(rerr));
      apb(0, 12'h0FC, 0); chk("unmapped", 32'h1, 32'(rerr));
      chk("unmapped_data", 32'h0, rdata);
   endtask

   // bypass latency, output coding and interface mode
   task automatic t_latency();
      logic [DW-1:0] e;
      ramp_on = 1'b1;
      apb(1, offset_correction_pkg::ADDR_CORR_CTRL, 32'h0000_00C0);
      repeat (12) @(posedge pclk);
      e = adc_sample - 14'd10;
      chk("bypass_word", 32'(e), 32'(out_data));
      apb(1, offset_correction_pkg::ADDR_CORR_CTRL, 32'h0000_0081);
      repeat (12) @(posedge pclk);
      e = (adc_sample - 14'd10) ^ 14'h2000;
      chk("twos_word", 32'(e), 32'(out_data));
      chk("ddr", 32'h1, 32'(ddr_mode));
      apb(1, offset_correction_pkg::ADDR_CORR_CTRL, 0);
      format_pin <= 1'b1;
      repeat (12) @(posedge pclk);
      chk("pin_twos", 32'h1, 32'(out_twos));
      // clock enable low: the output word must not move while the ramp runs on
      ce <= 1'b0;
      @(posedge pclk);
      e = out_data;
      repeat (5) @(posedge pclk);
      chk("ce_freeze", 32'(e), 32'(out_data));
      ce <= 1'b1;
      format_pin <= 1'b0;
      ramp_on = 1'b0;
   endtask

   // loop convergence, pedestal, hold, resume, span and gating
   task automatic t_loop();
      adc_sample <= 14'h2100;
      apb(1, offset_correction_pkg::ADDR_CORR_CTRL, 32'h0000_00E8);
      wait_rx("converged", 14'h2000, 600);
      chk("corr_on", 32'h1, 32'(correction_active));
      apb(1, offset_correction_pkg::ADDR_PEDESTAL, 32'h0000_0014);
      wait_rx("pedestal", 14'h2005, 600);
      apb(1, offset_correction_pkg::ADDR_LOOP_CTRL, 32'h0000_0080);
      adc_sample <= 14'h2200;
      repeat (40) @(posedge pclk);
      chk("held_word", 32'h0000_2105, 32'(rx_word));
      apb(0, offset_correction_pkg::ADDR_ESTIMATE, 0); chk("held_est", 32'h0000_00FB, rdata);
      apb(1, offset_correction_pkg::ADDR_LOOP_CTRL, 0);
      repeat (12) @(posedge pclk);
      chk("resume", 32'h1, 32'(rx_word <= 14'h2105));
      wait_rx("resumed", 14'h2005, 600);
      apb(1, offset_correction_pkg::ADDR_CORR_CTRL, 32'h0000_00E0);
      wait_rx("path_off", 14'h2200, 40);
      chk("corr_off", 32'h0, 32'(correction_active));
      apb(1, offset_correction_pkg::ADDR_LOOP_CTRL, 32'h0000_002C);
      apb(1, offset_correction_pkg::ADDR_CORR_CTRL, 32'h0000_00E8);
      repeat (40) @(posedge pclk);
      chk("slow_span", 32'h1, 32'(rx_word > 14'h21F0));
      apb(1, offset_correction_pkg::ADDR_CORR_CTRL, 32'h0000_00C8);
      wait_rx("disabled", 14'h2200, 40);
      // negative pedestal: converge one code below mid-code
      apb(1, offset_correction_pkg::ADDR_LOOP_CTRL, 0);
      apb(1, offset_correction_pkg::ADDR_PEDESTAL, 32'h0000_00FC);
      apb(1, offset_correction_pkg::ADDR_CORR_CTRL, 32'h0000_00E8);
      wait_rx("neg_pedestal", 14'h1FFF, 600);
   endtask

   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_latency();
      t_loop();
      give_verdict();
   end
endmodule
